//--- rtl/lhp_defines.svh
// constants for the lcd controller host port
// assumes a 50 MHz system clock
`ifndef LHP_DEFINES_SVH
`define LHP_DEFINES_SVH
`define LHP_CLK_NS 20
`define LHP_EXEC_NS 2000
`define LHP_EXEC_CYC ((`LHP_EXEC_NS) / (`LHP_CLK_NS))
`define LHP_CP_HALF_NS 800
`define LHP_CP_HALF_CYC (((`LHP_CP_HALF_NS) + (`LHP_CLK_NS) - 1) / (`LHP_CLK_NS))
`define LHP_BITS_PER_LINE 40
`define LHP_ADDR_RST 7'h00
`define LHP_DATA_RST 8'h00
`define LHP_CMD_RST 8'h00
`endif

//--- rtl/lhp_pkg.sv
// types for the lcd controller host port
// shared by the design file and the bench files
package lhp_pkg;
    typedef enum logic [1:0] {
        LHP_IDLE = 2'b00,
        LHP_EXEC = 2'b01
    } lhp_state_t;
    typedef struct packed {
        logic sel_data;
        logic rd;
        logic [7:0] wdata;
    } lhp_req_t;
    typedef struct packed {
        logic shift_clk;
        logic latch;
        logic alt;
        logic sdata;
    } lhp_exp_t;
endpackage

//--- rtl/lhp_host_port.sv
// host access port and expansion outputs of a character lcd controller
// assumes host pins asynchronous to CLK_SYS; strobe pulse >= 3 clocks
// How it works
// [R1] select high picks data register, low picks command register
// [R2] direction low is write, high is read
// [R3] every access is taken on the execution strobe's falling edge
// [R4] upper four lines carry 4-bit data or high nibble; released when idle
// [R5] lower four lines carry low nibble; ignored in 4-bit mode
// [R6] top data line shows busy during status read
// [R7] command write loads command register and starts execution
// [R8] status read gives busy on bit 7, address counter on bits 6..0
// [R9] data write loads data register then stores it into ram
// [R10] data read returns data register fetched from ram
// [R11] command register is never read back
// [R12] command value is decoded as instruction or ram address
// [R13] busy is 1 while executing, 0 once done
// [R14] command writes during busy are refused
// [R15] host polls busy low before the next command write
// [R16] latch strobe pulses after each shifted line
// [R17] one shift clock per serial pixel bit
// [R18] alternation toggles each line to keep the panel ac driven
// [R19] serial pixel is 1 when lit, 0 when dark
// [R20] unused common outputs carry the unselected waveform
// [R21] status address is the value before the running instruction
// [R22] after a data read the next ram word is prefetched
// [R23] 4-bit transfers go as two strobed nibbles, high first
`include "lhp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module lhp_host_port
    import lhp_pkg::*;
#(
    parameter int RAM_DEPTH = 128,
    parameter int COMMONS = 16,
    parameter int USED_COMMONS = 8
)
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic REGISTER_SELECT,
    input wire logic READ_NOT_WRITE,
    input wire logic EXEC_STROBE,
    input wire logic WIDTH_8BIT,
    input wire logic [7:0] HOST_DATA_LINES_I,
    output logic [7:0] HOST_DATA_LINES_O,
    output logic [7:0] HOST_DATA_LINES_OE_N,
    output logic BUSY_INDICATION,
    output logic EXPANSION_SHIFT_CLOCK,
    output logic EXPANSION_LATCH,
    output logic EXPANSION_ALT,
    output logic EXPANSION_DATA,
    output logic [COMMONS-1:0] COMMON_SELECT
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] e_s1_q, e_s2_q;
    logic e_s3_q;
    logic [7:0] d_s1_q, d_s2_q;
    logic w8_s1_q, w8_s2_q;
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            e_s1_q <= 3'h0;
            e_s2_q <= 3'h0;
            e_s3_q <= 1'b0;
            d_s1_q <= 8'h00;
            d_s2_q <= 8'h00;
            w8_s1_q <= 1'b0;
            w8_s2_q <= 1'b0;
        end
        else
        begin
            e_s1_q <= {EXEC_STROBE, REGISTER_SELECT, READ_NOT_WRITE};
            e_s2_q <= e_s1_q;
            e_s3_q <= e_s2_q[2];
            d_s1_q <= HOST_DATA_LINES_I;
            d_s2_q <= d_s1_q;
            w8_s1_q <= WIDTH_8BIT;
            w8_s2_q <= w8_s1_q;
        end
    end
    logic strobe_fall;
    logic strobe_high;
    lhp_req_t req;
    assign strobe_high = e_s2_q[2];
    assign strobe_fall = e_s3_q & ~e_s2_q[2]; // [R3]
    assign req.sel_data = e_s2_q[1]; // [R1]
    assign req.rd = e_s2_q[0]; // [R2]
    // [R5] low nibble ignored in 4-bit mode
    assign req.wdata = w8_s2_q ? d_s2_q : {d_s2_q[7:4], 4'h0};
    // ------------------------------------------------------------
    // register file and execution
    // ------------------------------------------------------------
    lhp_state_t state_q, state_d;
    logic [7:0] cmd_q, cmd_d, data_q, data_d, hold_q, hold_d;
    logic [6:0] addr_q, addr_d, addr_shown_q, addr_shown_d;
    logic [15:0] cnt_q, cnt_d;
    logic nib_q, nib_d;
    logic [7:0] ram_q [RAM_DEPTH];
    logic ram_we;
    logic [7:0] rd_word, wr_word;
    logic xfer_done;
    assign wr_word = w8_s2_q ? req.wdata : {hold_q[7:4], req.wdata[7:4]};
    // 4-bit: first strobe only holds the high nibble
    assign xfer_done = strobe_fall & (w8_s2_q | nib_q); // [R23]
    always_comb
    begin
        state_d = state_q;
        cmd_d = cmd_q;
        data_d = data_q;
        addr_d = addr_q;
        addr_shown_d = addr_shown_q;
        cnt_d = cnt_q;
        hold_d = hold_q;
        nib_d = nib_q;
        ram_we = 1'b0;
        if (strobe_fall && !w8_s2_q)
        begin
            nib_d = ~nib_q; // [R23]
            hold_d = req.wdata;
        end
        if (state_q == LHP_EXEC)
        begin
            if (cnt_q == 16'h0001)
            begin
                state_d = LHP_IDLE; // [R13]
            end
            cnt_d = cnt_q - 16'h0001;
        end
        if (xfer_done)
        begin
            if (!req.sel_data && !req.rd && state_q == LHP_IDLE) // [R14]
            begin
                cmd_d = wr_word; // [R7]
                state_d = LHP_EXEC;
                addr_shown_d = addr_q; // [R21]
                cnt_d = 16'(`LHP_EXEC_CYC);
                if (wr_word[7]) // [R12]
                begin
                    addr_d = wr_word[6:0];
                    data_d = ram_q[wr_word[6:0]];
                end
            end
            else if (req.sel_data && !req.rd)
            begin
                data_d = wr_word; // [R9]
                ram_we = 1'b1;
                addr_d = addr_q + 7'h01;
            end
            else if (req.sel_data && req.rd)
            begin
                addr_d = addr_q + 7'h01; // [R22]
                data_d = ram_q[addr_q + 7'h01];
            end
        end
    end
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            state_q <= LHP_IDLE;
            cmd_q <= `LHP_CMD_RST;
            data_q <= `LHP_DATA_RST;
            addr_q <= `LHP_ADDR_RST;
            addr_shown_q <= `LHP_ADDR_RST;
            cnt_q <= 16'h0000;
            hold_q <= 8'h00;
            nib_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cmd_q <= cmd_d;
            data_q <= data_d;
            addr_q <= addr_d;
            addr_shown_q <= addr_shown_d;
            cnt_q <= cnt_d;
            hold_q <= hold_d;
            nib_q <= nib_d;
        end
    end
    always_ff @(posedge CLK_SYS)
    begin
        if (ram_we)
        begin
            ram_q[addr_q] <= wr_word;
        end
    end
    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [7:0] dout_q, dout_d;
    logic drive_q, drive_d;
    always_comb
    begin
        // [R8] [R11] command register never appears here
        // idle shows the live counter, busy the pre-command value
        rd_word = req.sel_data ? data_q // [R10]
                : {state_q == LHP_EXEC, // [R6]
                   state_q == LHP_EXEC ? addr_shown_q : addr_q}; // [R21]
        dout_d = (w8_s2_q || !nib_q) ? rd_word : {rd_word[3:0], 4'h0};
        drive_d = strobe_high & req.rd;
    end
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            dout_q <= 8'h00;
            drive_q <= 1'b0;
        end
        else
        begin
            dout_q <= dout_d;
            drive_q <= drive_d;
        end
    end
    assign HOST_DATA_LINES_O = dout_q;
    // [R4] [R5] released unless read; low nibble idle in 4-bit mode
    assign HOST_DATA_LINES_OE_N = {{4{~drive_q}}, {4{~(drive_q & w8_s2_q)}}};
    assign BUSY_INDICATION = (state_q == LHP_EXEC); // [R13]
    // ------------------------------------------------------------
    // serial expansion output
    // ------------------------------------------------------------
    logic [15:0] half_q, half_d;
    logic [6:0] bit_q, bit_d;
    logic cp_q, cp_d, ld_q, ld_d, m_q, m_d, sd_q, sd_d;
    always_comb
    begin
        half_d = half_q + 16'h0001;
        cp_d = cp_q;
        bit_d = bit_q;
        ld_d = 1'b0;
        m_d = m_q;
        sd_d = sd_q;
        if (half_q == 16'(`LHP_CP_HALF_CYC - 1))
        begin
            half_d = 16'h0000;
            cp_d = ~cp_q; // [R17]
            if (cp_q)
            begin
                // latch only after the last bit has been clocked in
                if (bit_q == 7'(`LHP_BITS_PER_LINE - 1))
                begin
                    bit_d = 7'h00;
                    ld_d = 1'b1; // [R16]
                    m_d = ~m_q; // [R18]
                end
                else
                begin
                    bit_d = bit_q + 7'h01;
                end
                // lit pixel from display ram bit
                sd_d = ram_q[bit_d][0]; // [R19]
            end
        end
    end
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            half_q <= 16'h0000;
            bit_q <= 7'h00;
            cp_q <= 1'b0;
            ld_q <= 1'b0;
            m_q <= 1'b0;
            sd_q <= 1'b0;
        end
        else
        begin
            half_q <= half_d;
            bit_q <= bit_d;
            cp_q <= cp_d;
            ld_q <= ld_d;
            m_q <= m_d;
            sd_q <= sd_d;
        end
    end
    assign EXPANSION_SHIFT_CLOCK = cp_q;
    assign EXPANSION_LATCH = ld_q;
    assign EXPANSION_ALT = m_q;
    assign EXPANSION_DATA = sd_q;
    // unused commons held unselected (0)
    genvar gi;
    generate
        for (gi = 0; gi < COMMONS; gi++)
        begin : g_com
            assign COMMON_SELECT[gi] = (gi < USED_COMMONS) ? m_q : 1'b0; // [R20]
        end
    endgenerate
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_busy_refuse: assert property (@(posedge CLK_SYS) disable iff (RST) // [R14]
        xfer_done && !req.sel_data && !req.rd && state_q == LHP_EXEC
        |=> $stable(cmd_q))
        else $error("command taken while busy");
    a_cmd_starts: assert property (@(posedge CLK_SYS) disable iff (RST) // [R7]
        xfer_done && !req.sel_data && !req.rd && state_q == LHP_IDLE
        |=> BUSY_INDICATION && cmd_q == $past(wr_word))
        else $error("command write did not start");
    a_busy_len: assert property (@(posedge CLK_SYS) disable iff (RST) // [R13]
        $rose(BUSY_INDICATION) |-> BUSY_INDICATION [*8])
        else $error("busy dropped early");
    a_data_write: assert property (@(posedge CLK_SYS) disable iff (RST) // [R9]
        xfer_done && req.sel_data && !req.rd |=> data_q == $past(wr_word))
        else $error("data write lost");
    a_status_bit7: assert property (@(posedge CLK_SYS) disable iff (RST) // [R8]
        strobe_high && req.rd && !req.sel_data && w8_s2_q
        |=> HOST_DATA_LINES_O[7] == $past(BUSY_INDICATION))
        else $error("status bit 7 wrong");
    a_release_bus: assert property (@(posedge CLK_SYS) disable iff (RST) // [R4]
        !strobe_high |=> HOST_DATA_LINES_OE_N == 8'hFF)
        else $error("bus driven outside read");
    a_low_nibble: assert property (@(posedge CLK_SYS) disable iff (RST) // [R5]
        !w8_s2_q |=> HOST_DATA_LINES_OE_N[3:0] == 4'hF)
        else $error("low nibble driven in 4-bit mode");
    a_latch_alt: assert property (@(posedge CLK_SYS) disable iff (RST) // [R18]
        ld_d |=> EXPANSION_LATCH && m_q != $past(m_q))
        else $error("alternation missed at latch");
    a_unused_com: assert property (@(posedge CLK_SYS) disable iff (RST) // [R20]
        COMMON_SELECT[COMMONS-1] == 1'b0)
        else $error("unused common selected");
    c_cmd: cover property (@(posedge CLK_SYS) disable iff (RST)
        $rose(BUSY_INDICATION));
    c_read: cover property (@(posedge CLK_SYS) disable iff (RST)
        xfer_done && req.sel_data && req.rd);
    c_latch: cover property (@(posedge CLK_SYS) disable iff (RST)
        EXPANSION_LATCH);
endmodule
`default_nettype wire

//--- bench/lhp_host_model.sv
// microcontroller model on the far side of the host port
// assumes lhp_pkg compiled first and the tb calling its tasks
`timescale 1ns/1ps
`default_nettype none
module lhp_host_model
    import lhp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [7:0] db_o,
    input wire logic [7:0] db_oe_n,
    output logic rs,
    output logic rnw,
    output logic strobe,
    output logic [7:0] db_i
);
    logic [7:0] drv = 8'hFF;
    logic drv_en = 1'b0;
    // released lines float high on the pull-ups
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            db_i[i] = !db_oe_n[i] ? db_o[i] : (drv_en ? drv[i] : 1'b1);
        end
    end
    initial
    begin
        rs = 1'b0;
        rnw = 1'b1;
        strobe = 1'b0;
    end
    // --------
    // transfers
    // --------
    // selects stay 4 clocks past the fall, three more than needed
    task automatic access(input lhp_req_t req, output logic [7:0] rd);
        @(posedge clk_sys);
        rs <= req.sel_data;
        rnw <= req.rd;
        drv <= req.wdata;
        drv_en <= !req.rd;
        @(posedge clk_sys);
        strobe <= 1'b1;
        repeat (5) @(posedge clk_sys);
        rd = db_i;
        strobe <= 1'b0;
        repeat (4) @(posedge clk_sys);
        drv_en <= 1'b0;
    endtask
    task automatic xfer(input logic sel, input logic r, input logic [7:0] wb,
                        input logic wide, output logic [7:0] rb);
        logic [7:0] a;
        logic [7:0] b;
        if (wide)
            access('{sel, r, wb}, rb);
        else
        begin
            // junk on the low lines, which must not matter
            access('{sel, r, {wb[7:4], 4'($urandom)}}, a);
            access('{sel, r, {wb[3:0], 4'($urandom)}}, b);
            rb = {a[7:4], b[7:4]};
        end
    endtask
    task automatic wait_free(input logic wide, output logic [7:0] st);
        st = 8'h80;
        for (int n = 0; n < 40 && st[7]; n++)
            xfer(1'b0, 1'b1, 8'h00, wide, st);
    endtask
endmodule
`default_nettype wire

//--- bench/test_lcd_controller_host_port.sv
// self-checking bench for the lcd controller host port
// assumes lhp_pkg, lhp_host_port and lhp_host_model compiled first
`include "lhp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module test_lcd_controller_host_port
    import lhp_pkg::*;
;
    logic clk_sys;
    logic rst;
    logic width_8bit;
    logic rs;
    logic rnw;
    logic strobe;
    logic busy;
    logic sclk;
    logic latch;
    logic alt;
    logic last_alt;
    logic last_sclk;
    logic sdata;
    logic [7:0] db_i;
    logic [7:0] db_o;
    logic [7:0] db_oe_n;
    logic [7:0] got;
    logic [15:0] commons;
    logic [7:0] ram [128];
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    int lines;
    int blen;
    int rises;
    lhp_host_port i_dut (.CLK_SYS(clk_sys), .RST(rst),
        .REGISTER_SELECT(rs), .READ_NOT_WRITE(rnw), .EXEC_STROBE(strobe),
        .WIDTH_8BIT(width_8bit), .HOST_DATA_LINES_I(db_i),
        .HOST_DATA_LINES_O(db_o), .HOST_DATA_LINES_OE_N(db_oe_n),
        .BUSY_INDICATION(busy), .EXPANSION_SHIFT_CLOCK(sclk),
        .EXPANSION_LATCH(latch), .EXPANSION_ALT(alt), .EXPANSION_DATA(sdata),
        .COMMON_SELECT(commons));
    lhp_host_model i_host (.clk_sys(clk_sys), .db_o(db_o),
        .db_oe_n(db_oe_n), .rs(rs), .rnw(rnw), .strobe(strobe), .db_i(db_i));
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic summarize();
        $display("%0d checks, %0d wrong", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            num_errors++;
            summarize();
        end
    end
    // --------
    // monitors
    // --------
    // the first line after reset is partial, so it is not judged
    always @(posedge clk_sys)
    begin
        last_sclk <= sclk;
        if (rst)
        begin
            blen <= 0;
            rises <= 0;
            lines <= 0;
        end
        else
        begin
            blen <= busy ? blen + 1 : 0;
            if (!busy && blen > 0)
                check(16'(blen), 16'(`LHP_EXEC_CYC));
            rises <= rises + int'(sclk && !last_sclk);
            if (sclk && !last_sclk && lines > 0 && !$isunknown(ram[rises]))
                check(sdata, ram[rises][0]);
            if (latch)
            begin
                if (lines > 0)
                begin
                    check(16'(rises), 16'(`LHP_BITS_PER_LINE));
                    check(alt, !last_alt);
                    check(commons, {8'h00, {8{alt}}});
                end
                rises <= 0;
                last_alt <= alt;
                lines <= lines + 1;
            end
        end
    end
    task automatic run_mode(input logic w);
        logic [7:0] a;
        logic [7:0] d;
        width_8bit <= w;
        rst <= 1'b1;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        check(db_oe_n, 8'hFF);
        check({busy, db_o}, 9'h000);
        a = w ? 8'h7C : 8'($urandom_range(0, 127));
        i_host.xfer(1'b0, 1'b0, {1'b1, a[6:0]}, w, got);
        i_host.xfer(1'b0, 1'b1, 8'h00, w, got);
        check(got, {1'b1, `LHP_ADDR_RST});
        check(busy, 1'b1);
        // lands while busy and must leave the address alone
        i_host.xfer(1'b0, 1'b0, {1'b1, ~a[6:0]}, w, got);
        i_host.wait_free(w, got);
        check(got, {1'b0, a[6:0]});
        // in 8-bit mode the run from 7C near the top of ram crosses the wrap
        for (int i = 0; i < 6; i++)
        begin
            d = 8'($urandom);
            ram[7'(a + i)] = d;
            i_host.xfer(1'b1, 1'b0, d, w, got);
        end
        i_host.wait_free(w, got);
        check(got, {1'b0, 7'(a + 6)});
        i_host.xfer(1'b0, 1'b0, {1'b1, a[6:0]}, w, got);
        i_host.wait_free(w, got);
        for (int i = 0; i < 6; i++)
        begin
            i_host.xfer(1'b1, 1'b1, 8'h00, w, got);
            check(got, ram[7'(a + i)]);
        end
        $display("test width %0d done", w ? 8 : 4);
    endtask
    initial
    begin
        got = 8'($urandom(32'h6A32));
        run_mode(1'b1);
        run_mode(1'b0);
        while (lines < 3)
            @(posedge clk_sys);
        $display("test expansion done");
        summarize();
    end
endmodule
`default_nettype wire
